// *** inc/bfsm_regs.svh ***
// timing counts, offsets, fields and reset values for the bridge fault state manager
`ifndef BFSM_REGS_SVH
`define BFSM_REGS_SVH
`define BFSM_CLK_HZ        20000000
`define BFSM_OLA_CYCLES    2'd3
// filter and deglitch times in ns and derived cycle counts at 50 ns
`define BFSM_T_OV_NS       1000
`define BFSM_T_UV_NS       1000
`define BFSM_T_POR_NS      1000
`define BFSM_T_WAKE_NS     2000
`define BFSM_COMM_READY_TIME_NS      5000
`define BFSM_T_READY_NS    10000
`define BFSM_T_RESET_NS    1000
`define BFSM_T_SLEEP_NS    20000
`define BFSM_OVERCURRENT_FILTER_TIME_NS      1000
`define BFSM_NS_TO_CYC(t)  (((t) + 49) / 50)
// apb register offsets
`define BFSM_CFG_ADDR      12'h000
`define BFSM_STAT_ADDR     12'h004
// configuration bit positions
`define BFSM_CFG_OLA_EN    0
`define BFSM_CFG_OLA_RETRY 1
`define BFSM_CFG_OV_EN     2
`define BFSM_CFG_OV_RETRY  3
`define BFSM_CFG_UV_RETRY  4
`define BFSM_CFG_OV_SEL    5
`define BFSM_CFG_PWM_MODE  6
`define BFSM_CFG_RESET     8'h1B
`endif

// *** inc/bfsm_pkg.sv ***
// types shared by the bridge fault state manager
package bfsm_pkg;
    typedef enum logic [1:0] {
        BFSM_SLEEP   = 2'b00,
        BFSM_WAKE    = 2'b01,
        BFSM_STANDBY = 2'b10,
        BFSM_ACTIVE  = 2'b11
    } bfsm_state_e;
    typedef enum logic [2:0] {
        BFSM_PULSE_NONE  = 3'b000,
        BFSM_PULSE_UNDET = 3'b001,
        BFSM_PULSE_CLR   = 3'b010,
        BFSM_PULSE_CLRSU = 3'b011,
        BFSM_PULSE_SLEEP = 3'b100
    } bfsm_pulse_e;
endpackage : bfsm_pkg

// *** inc/bfsm_pulse_if.sv ***
// sleep-pin pulse decoder results carried to the state manager
`timescale 1ns/100ps
`default_nettype none
interface bfsm_pulse_if;
    logic clear_fault;
    logic sleep_cmd;
    logic wake_cmd;
    logic pin_high;
    modport decoder (output clear_fault, output sleep_cmd, output wake_cmd, output pin_high);
    modport manager (input clear_fault, input sleep_cmd, input wake_cmd, input pin_high);
endinterface : bfsm_pulse_if
`default_nettype wire

// *** hdl/bfsm_pulse_decode.sv ***
// decodes sleep-pin low and high pulse widths into commands
`timescale 1ns/100ps
`default_nettype none
`include "bfsm_regs.svh"
module bfsm_pulse_decode (
    input  wire logic          clk_in,
    input  wire logic          rst_in,
    input  wire logic          sleep_n_in,
    bfsm_pulse_if.decoder      pulse
);
    localparam int RST_MIN = `BFSM_NS_TO_CYC(`BFSM_T_RESET_NS);
    localparam int SLP_MIN = `BFSM_NS_TO_CYC(`BFSM_T_SLEEP_NS);
    localparam int WAKE_C  = `BFSM_NS_TO_CYC(`BFSM_T_WAKE_NS);
    localparam logic [15:0] RST_C  = RST_MIN[15:0];
    localparam logic [15:0] SLP_C  = SLP_MIN[15:0];
    localparam logic [15:0] WAK_C  = WAKE_C[15:0];

    typedef struct packed {
        logic [15:0] low_cnt;
        logic [15:0] high_cnt;
        logic        prev;
        logic        slept;
        logic        clr;
        logic        slp;
        logic        wake;
    } bfsm_dec_s;

    bfsm_dec_s st;
    bfsm_dec_s next_st;

    // width counting: a release ends a low pulse and classifies it
    always_comb begin
        next_st      = st;
        next_st.prev = sleep_n_in;
        next_st.clr  = 1'b0;
        next_st.wake = 1'b0;
        if (!sleep_n_in) begin
            next_st.high_cnt = 16'h0000;
            if (st.low_cnt != 16'hFFFF) next_st.low_cnt = st.low_cnt + 16'h0001;
            // long low asserts sleep while still held
            if (st.low_cnt >= SLP_C && !st.slept) begin
                next_st.slp   = 1'b1;
                next_st.slept = 1'b1;
            end else begin
                next_st.slp = 1'b0;
            end
        end else begin
            next_st.slp     = 1'b0;
            next_st.low_cnt = 16'h0000;
            // short pulses ignored, longer ones clear
            if (!st.prev && st.low_cnt >= RST_C) next_st.clr = 1'b1;
            next_st.slept = 1'b0;
            if (st.high_cnt != 16'hFFFF) next_st.high_cnt = st.high_cnt + 16'h0001;
            next_st.wake = (st.high_cnt == WAK_C); // held high past wake time
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st      <= '0;
            st.prev <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign pulse.clear_fault = st.clr;
    assign pulse.sleep_cmd   = st.slp;
    assign pulse.wake_cmd    = st.wake;
    assign pulse.pin_high    = st.prev;
endmodule : bfsm_pulse_decode
`default_nettype wire

// *** hdl/bfsm_top.sv ***
// fault supervision and functional state control for a motor bridge driver
`timescale 1ns/100ps
`default_nettype none
`include "bfsm_regs.svh"
module bfsm_top (
    input  wire logic        CLK_IN,
    input  wire logic        RST_IN,
    input  wire logic        SLEEP_IN_N_IN,
    input  wire logic        DRIVER_OFF_IN,
    input  wire logic        BRIDGE_INPUT_A_IN,
    input  wire logic        BRIDGE_INPUT_B_IN,
    input  wire logic        SUPPLY_OV_CMP_IN,
    input  wire logic        SUPPLY_OV_ALT_CMP_IN,
    input  wire logic        SUPPLY_UV_CMP_IN,
    input  wire logic        LOGIC_POR_CMP_IN,
    input  wire logic        THERMAL_SHUTDOWN_IN,
    input  wire logic        OVERCURRENT_RAW_IN,
    input  wire logic        CURRENT_LIMIT_CHOP_IN,
    input  wire logic        RECIRC_EDGE_IN,
    input  wire logic        RECIRC_HIGH_SIDE_IN,
    input  wire logic        SPIKE_SEEN_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [11:0] PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    output logic             FAULT_OUT_N_OUT,
    output logic             FAULT_OUT_N_OE_OUT,
    output logic             BRIDGE_OUTPUT_A_OUT,
    output logic             BRIDGE_OUTPUT_B_OUT,
    output logic             BRIDGE_OUTPUT_OE_OUT,
    output logic             CURRENT_PROP_OE_OUT,
    output logic             OFFSTATE_DIAG_EN_OUT,
    output logic [1:0]       STATE_OUT
);
    // filter lengths as cycle counts
    localparam int OV_I   = `BFSM_NS_TO_CYC(`BFSM_T_OV_NS);
    localparam int UV_I   = `BFSM_NS_TO_CYC(`BFSM_T_UV_NS);
    localparam int POR_I  = `BFSM_NS_TO_CYC(`BFSM_T_POR_NS);
    localparam int COM_I  = `BFSM_NS_TO_CYC(`BFSM_COMM_READY_TIME_NS);
    localparam int RDY_I  = `BFSM_NS_TO_CYC(`BFSM_T_READY_NS);
    localparam int OCP_I  = `BFSM_NS_TO_CYC(`BFSM_OVERCURRENT_FILTER_TIME_NS);
    localparam logic [15:0] OV_C  = OV_I[15:0];
    localparam logic [15:0] UV_C  = UV_I[15:0];
    localparam logic [15:0] POR_C = POR_I[15:0];
    localparam logic [15:0] COM_C = COM_I[15:0];
    localparam logic [15:0] RDY_C = RDY_I[15:0];
    localparam logic [15:0] OCP_C = OCP_I[15:0];

    typedef struct packed {
        bfsm_pkg::bfsm_state_e state;
        logic [7:0]  cfg;
        logic [15:0] ov_cnt;
        logic [15:0] uv_cnt;
        logic [15:0] por_cnt;
        logic [15:0] ocp_cnt;
        logic [15:0] wake_cnt;
        logic        comm_ok;
        logic        ready;
        logic        ov_flag;
        logic        uv_flag;
        logic        ocp_flag;
        logic        ola_flag;
        logic        ola_dir;
        logic [1:0]  ola_miss;
        logic [1:0]  ola_hit;
        logic        sw_clear;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        fault_low;
        logic        out_a;
        logic        out_b;
        logic        out_oe;
        logic        iprop_oe;
        logic        diag_en;
    } bfsm_top_s;

    bfsm_top_s r;
    bfsm_top_s n;

    bfsm_pulse_if pulse ();

    bfsm_pulse_decode u_decode (
        .clk_in     (CLK_IN),
        .rst_in     (RST_IN),
        .sleep_n_in (SLEEP_IN_N_IN),
        .pulse      (pulse.decoder)
    );

    logic ov_cmp;
    logic ov_filt;
    logic uv_filt;
    logic por_filt;
    logic clear_req;
    logic dir_now;
    logic ocp_pending;

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        n          = r;
        n.pready   = 1'b0;
        n.pslverr  = 1'b0;
        n.sw_clear = 1'b0;
        // threshold select picks the alternate comparator
        ov_cmp   = r.cfg[`BFSM_CFG_OV_SEL] ? SUPPLY_OV_ALT_CMP_IN : SUPPLY_OV_CMP_IN;
        ov_cmp   = ov_cmp & r.cfg[`BFSM_CFG_OV_EN];
        ov_filt  = (r.ov_cnt >= OV_C);
        uv_filt  = (r.uv_cnt >= UV_C);
        por_filt = LOGIC_POR_CMP_IN && (r.por_cnt >= POR_C);
        clear_req = pulse.clear_fault | r.sw_clear;
        dir_now   = BRIDGE_INPUT_B_IN;
        ocp_pending = OVERCURRENT_RAW_IN && (r.ocp_cnt < OCP_C);

        // apb slave, one wait state per access phase
        if (PSEL_IN && PENABLE_IN && !r.pready) begin
            n.pready = 1'b1;
            if (PADDR_IN == `BFSM_CFG_ADDR) begin
                if (PWRITE_IN) n.cfg = PWDATA_IN[7:0];
                n.prdata = {24'h000000, r.cfg};
            end else if (PADDR_IN == `BFSM_STAT_ADDR) begin
                if (PWRITE_IN && PWDATA_IN[31]) n.sw_clear = 1'b1; // acknowledge or clear
                n.prdata = {22'h000000, r.ola_dir, r.ocp_flag, r.ola_flag, r.uv_flag, r.ov_flag,
                            r.ready, r.comm_ok, r.fault_low, r.state};
            end else begin
                n.prdata  = 32'h00000000;
                n.pslverr = 1'b1;
            end
        end

        // supply and overcurrent filters
        n.ov_cnt  = ov_cmp ? ((r.ov_cnt == 16'hFFFF) ? r.ov_cnt : r.ov_cnt + 16'h0001) : 16'h0000;
        n.uv_cnt  = SUPPLY_UV_CMP_IN ? ((r.uv_cnt == 16'hFFFF) ? r.uv_cnt : r.uv_cnt + 16'h0001) : 16'h0000;
        n.por_cnt = LOGIC_POR_CMP_IN ? ((r.por_cnt == 16'hFFFF) ? r.por_cnt : r.por_cnt + 16'h0001) : 16'h0000;
        n.ocp_cnt = OVERCURRENT_RAW_IN ? ((r.ocp_cnt == 16'hFFFF) ? r.ocp_cnt : r.ocp_cnt + 16'h0001)
                                       : 16'h0000;

        // flags in standby and active
        if (r.state == bfsm_pkg::BFSM_STANDBY || r.state == bfsm_pkg::BFSM_ACTIVE) begin
            // over-voltage: latched needs clear, retry follows supply
            if (ov_filt) n.ov_flag = 1'b1;
            else if (r.cfg[`BFSM_CFG_OV_RETRY] || clear_req) n.ov_flag = 1'b0;
            // under-voltage: latched needs clear, retry follows supply
            if (uv_filt) n.uv_flag = 1'b1;
            else if (r.cfg[`BFSM_CFG_UV_RETRY] || clear_req) n.uv_flag = 1'b0;
            if (!ocp_pending && OVERCURRENT_RAW_IN) n.ocp_flag = 1'b1;
            else if (clear_req) n.ocp_flag = 1'b0;
        end

        // on-state open load, high-side recirculation only
        if (r.state == bfsm_pkg::BFSM_ACTIVE && r.cfg[`BFSM_CFG_OLA_EN] && RECIRC_EDGE_IN
            && RECIRC_HIGH_SIDE_IN) begin
            if (SPIKE_SEEN_IN) begin
                n.ola_miss = 2'd0;
                if (r.ola_hit != `BFSM_OLA_CYCLES) n.ola_hit = r.ola_hit + 2'd1;
                // retry clears after three good cycles
                if (r.ola_hit == `BFSM_OLA_CYCLES - 2'd1 && r.cfg[`BFSM_CFG_OLA_RETRY]) n.ola_flag = 1'b0;
            end else begin
                n.ola_hit = 2'd0;
                if (r.ola_miss != `BFSM_OLA_CYCLES) n.ola_miss = r.ola_miss + 2'd1;
                if (r.ola_miss == `BFSM_OLA_CYCLES - 2'd1) begin
                    n.ola_flag = 1'b1;
                    n.ola_dir  = dir_now;
                end
            end
        end else if (clear_req && r.ola_flag && dir_now == r.ola_dir && !n.ola_flag) begin
            n.ola_flag = 1'b1;
        end
        // clear only in the detection direction; a new detection wins
        if (clear_req && r.ola_flag && dir_now == r.ola_dir
            && !(RECIRC_EDGE_IN && RECIRC_HIGH_SIDE_IN && !SPIKE_SEEN_IN)) begin
            n.ola_flag = 1'b0;
        end
        if (!r.cfg[`BFSM_CFG_OLA_EN]) begin
            n.ola_flag = 1'b0;
            n.ola_miss = 2'd0;
        end

        // functional states
        case (r.state)
            bfsm_pkg::BFSM_SLEEP: begin
                n.wake_cnt = 16'h0000;
                n.comm_ok  = 1'b0;
                n.ready    = 1'b0;
                if (pulse.wake_cmd && !por_filt) n.state = bfsm_pkg::BFSM_WAKE;
            end
            bfsm_pkg::BFSM_WAKE: begin
                if (r.wake_cnt != 16'hFFFF) n.wake_cnt = r.wake_cnt + 16'h0001;
                if (r.wake_cnt >= COM_C) n.comm_ok = 1'b1; // fault low once able to talk
                if (r.wake_cnt >= COM_C + RDY_C) n.ready = 1'b1;
                if (r.ready && clear_req) n.state = bfsm_pkg::BFSM_STANDBY; // acknowledge
            end
            bfsm_pkg::BFSM_STANDBY: begin
                // active only from here
                if (DRIVER_OFF_IN == 1'b0 && !(r.cfg[`BFSM_CFG_PWM_MODE] && BRIDGE_INPUT_A_IN
                    && BRIDGE_INPUT_B_IN)) begin
                    n.state = bfsm_pkg::BFSM_ACTIVE;
                end
            end
            bfsm_pkg::BFSM_ACTIVE: begin
                if (DRIVER_OFF_IN || (r.cfg[`BFSM_CFG_PWM_MODE] && BRIDGE_INPUT_A_IN && BRIDGE_INPUT_B_IN))
                    n.state = bfsm_pkg::BFSM_STANDBY;
            end
            default: n.state = bfsm_pkg::BFSM_SLEEP;
        endcase
        // sleep command or supply reset overrides
        if (por_filt) begin
            n.state    = bfsm_pkg::BFSM_SLEEP;
            n.ov_flag  = 1'b0;
            n.uv_flag  = 1'b0;
            n.ocp_flag = 1'b0;
            n.ola_flag = 1'b0;
        end else if (r.state == bfsm_pkg::BFSM_SLEEP && !LOGIC_POR_CMP_IN && r.por_cnt >= POR_C) begin
            n.state = bfsm_pkg::BFSM_WAKE; // reset release rewakes
        end else if (pulse.sleep_cmd && r.state != bfsm_pkg::BFSM_SLEEP) begin
            n.state = bfsm_pkg::BFSM_SLEEP;
        end

        // fault pin: low in wake after comm, or any flag in standby/active
        n.fault_low = 1'b0;
        if (n.state == bfsm_pkg::BFSM_WAKE) n.fault_low = n.comm_ok;
        else if (n.state == bfsm_pkg::BFSM_ACTIVE || n.state == bfsm_pkg::BFSM_STANDBY)
            n.fault_low = n.ov_flag | n.uv_flag | n.ola_flag | n.ocp_flag | THERMAL_SHUTDOWN_IN;

        // output priority arbitration
        n.out_a    = 1'b0;
        n.out_b    = 1'b0;
        n.out_oe   = 1'b0;
        n.iprop_oe = 1'b0;
        n.diag_en  = (n.state == bfsm_pkg::BFSM_STANDBY);
        if (n.state != bfsm_pkg::BFSM_ACTIVE || pulse.sleep_cmd || DRIVER_OFF_IN) begin
            n.out_oe = 1'b0; // priorities one and two
        end else if (THERMAL_SHUTDOWN_IN || n.ocp_flag || n.uv_flag) begin
            n.out_oe = 1'b0; // priorities three to five
        end else if (ocp_pending) begin
            n.out_oe   = r.out_oe; // hold while overcurrent qualifies
            n.out_a    = r.out_a;
            n.out_b    = r.out_b;
            n.iprop_oe = r.iprop_oe;
        end else begin
            n.out_oe   = 1'b1;
            n.iprop_oe = 1'b1;
            n.out_a    = BRIDGE_INPUT_A_IN & ~CURRENT_LIMIT_CHOP_IN; // chop above inputs
            n.out_b    = BRIDGE_INPUT_B_IN & ~CURRENT_LIMIT_CHOP_IN;
            // over-voltage and open-load flags intentionally not read here
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            r       <= '0;
            r.state <= bfsm_pkg::BFSM_SLEEP;
            r.cfg   <= `BFSM_CFG_RESET;
        end else begin
            r <= n;
        end
    end

    // outputs straight from the register, except fault data tied low
    assign PRDATA_OUT           = r.prdata;
    assign PREADY_OUT           = r.pready;
    assign PSLVERR_OUT          = r.pslverr;
    assign FAULT_OUT_N_OUT      = 1'b0;
    assign FAULT_OUT_N_OE_OUT   = r.fault_low; // open drain: enable pulls low
    assign BRIDGE_OUTPUT_A_OUT  = r.out_a;
    assign BRIDGE_OUTPUT_B_OUT  = r.out_b;
    assign BRIDGE_OUTPUT_OE_OUT = r.out_oe;
    assign CURRENT_PROP_OE_OUT  = r.iprop_oe;
    assign OFFSTATE_DIAG_EN_OUT = r.diag_en;
    assign STATE_OUT            = r.state;
endmodule : bfsm_top
`default_nettype wire

// *** test/bfsm_top_props.sv ***
// port checker for the bridge fault state manager
`timescale 1ns/100ps
`default_nettype none
module bfsm_top_props (
    input wire logic       CLK_IN,
    input wire logic       RST_IN,
    input wire logic       DRIVER_OFF_IN,
    input wire logic       SUPPLY_UV_CMP_IN,
    input wire logic       LOGIC_POR_CMP_IN,
    input wire logic       FAULT_OUT_N_OE_OUT,
    input wire logic       BRIDGE_OUTPUT_OE_OUT,
    input wire logic       CURRENT_PROP_OE_OUT,
    input wire logic [1:0] STATE_OUT
);
    logic [8:0] uv_cnt;
    logic [8:0] por_cnt;
    logic [8:0] wk_cnt;
    ////////////////////////////////////////////////////////////////////////////////
    // run lengths held at the cap, so long stays never wrap back to zero
    always_ff @(posedge CLK_IN) begin
        uv_cnt  <= (RST_IN || !SUPPLY_UV_CMP_IN) ? 9'h000 : uv_cnt + 9'(uv_cnt != 9'h1FF);
        por_cnt <= (RST_IN || !LOGIC_POR_CMP_IN) ? 9'h000 : por_cnt + 9'(por_cnt != 9'h1FF);
        wk_cnt  <= (RST_IN || STATE_OUT != 2'b01) ? 9'h000 : wk_cnt + 9'(wk_cnt != 9'h1FF);
    end
    ////////////////////////////////////////////////////////////////////////////////
    // margin of a few cycles past the filters covers the output registers
    property p_uv_hiz;
        @(posedge CLK_IN) disable iff (RST_IN) uv_cnt > 9'd25 |-> !BRIDGE_OUTPUT_OE_OUT && !CURRENT_PROP_OE_OUT;
    endproperty
    a_uv_hiz: assert property (p_uv_hiz) else $error("outputs driven in undervoltage");
    property p_por;
        @(posedge CLK_IN) disable iff (RST_IN) por_cnt > 9'd25 |-> STATE_OUT == 2'b00 && !FAULT_OUT_N_OE_OUT;
    endproperty
    a_por: assert property (p_por) else $error("supply loss did not reset");
    property p_sleep;
        @(posedge CLK_IN) disable iff (RST_IN) STATE_OUT == 2'b00 |-> !BRIDGE_OUTPUT_OE_OUT && !FAULT_OUT_N_OE_OUT;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep not quiet");
    property p_standby;
        @(posedge CLK_IN) disable iff (RST_IN) STATE_OUT == 2'b10 |-> !BRIDGE_OUTPUT_OE_OUT;
    endproperty
    a_standby: assert property (p_standby) else $error("standby drives bridge");
    property p_wake_hiz;
        @(posedge CLK_IN) disable iff (RST_IN) STATE_OUT == 2'b01 |-> !BRIDGE_OUTPUT_OE_OUT;
    endproperty
    a_wake_hiz: assert property (p_wake_hiz) else $error("wake drives bridge");
    property p_wake_fault;
        @(posedge CLK_IN) disable iff (RST_IN) wk_cnt == 9'd120 |-> FAULT_OUT_N_OE_OUT;
    endproperty
    a_wake_fault: assert property (p_wake_fault) else $error("wake fault not shown");
    property p_act_entry;
        @(posedge CLK_IN) disable iff (RST_IN) STATE_OUT == 2'b11 && $past(STATE_OUT) != 2'b11 |->
            $past(STATE_OUT) == 2'b10;
    endproperty
    a_act_entry: assert property (p_act_entry) else $error("active entered off standby");
    property p_driver_off_in;
        @(posedge CLK_IN) disable iff (RST_IN) DRIVER_OFF_IN [*3] |-> !BRIDGE_OUTPUT_OE_OUT;
    endproperty
    a_driver_off_in: assert property (p_driver_off_in) else $error("driver off ignored");
endmodule : bfsm_top_props
bind bfsm_top bfsm_top_props u_props (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .DRIVER_OFF_IN(DRIVER_OFF_IN),
    .SUPPLY_UV_CMP_IN(SUPPLY_UV_CMP_IN), .LOGIC_POR_CMP_IN(LOGIC_POR_CMP_IN),
    .FAULT_OUT_N_OE_OUT(FAULT_OUT_N_OE_OUT), .BRIDGE_OUTPUT_OE_OUT(BRIDGE_OUTPUT_OE_OUT),
    .CURRENT_PROP_OE_OUT(CURRENT_PROP_OE_OUT), .STATE_OUT(STATE_OUT));
`default_nettype wire

// *** test/bfsm_host_model.sv ***
// host controller model: drives the sleep pin, watches the fault line
`timescale 1ns/100ps
`default_nettype none
module bfsm_host_model #(
    parameter int READY_WAIT = 320
) (
    input  wire logic clk_in,
    input  wire logic fault_n_in,
    output var logic  sleep_n_out
);
    initial sleep_n_out = 1'b1;
    ////////////////////////////////////////////////////////////////////////////////
    // low pulse in whole cycles, edges just after the clock
    task automatic low_pulse(input int cycles);
        @(posedge clk_in);
        sleep_n_out <= 1'b0;
        repeat (cycles) @(posedge clk_in);
        sleep_n_out <= 1'b1;
    endtask : low_pulse
    // acknowledging before ready would be lost, so wait it out first
    task automatic ack_wake(output bit ok);
        ok = 1'b0;
        for (int i = 0; i < 2000 && !ok; i++) begin
            @(posedge clk_in);
            ok = !fault_n_in;
        end
        repeat (READY_WAIT) @(posedge clk_in);
        if (ok) low_pulse(30);
    endtask : ack_wake
endmodule : bfsm_host_model
`default_nettype wire

// *** test/bfsm_top_tb.sv ***
// self-checking bench for the bridge fault state manager
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin failures++; $display("BAD %s exp %h seen %h", nm, e, s); end end
module bfsm_top_tb;
    typedef struct { bit pin; logic [32:0] mask; logic [32:0] exp; } bfsm_note_s;
    bfsm_note_s  notes[$];
    bfsm_note_s  note;
    int          failures = 0, check_count = 0;
    logic        clk_in = 1'b0, rst_in = 1'b1, drv_off = 1'b1, in_a = 1'b1, in_b = 1'b0, snap_req = 1'b0;
    logic        ov = 1'b0, uv = 1'b0, por = 1'b0, rc_edge = 1'b0, hs = 1'b1, spike = 1'b0, thermal_shutdown = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwr = 1'b0, pready, pslverr, fault_n, fault_oe, br_oe, ip_oe, out_a;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata;
    logic [1:0]  state;
    wire         sleep_n, fault_line_n;
    ////////////////////////////////////////////////////////////////////////////////
    // fault pin is open drain with a pull-up
    assign fault_line_n = fault_oe ? fault_n : 1'b1;
    always #25 clk_in = ~clk_in;
    bfsm_host_model u_host (.clk_in(clk_in), .fault_n_in(fault_line_n), .sleep_n_out(sleep_n));
    bfsm_top u_dut (.CLK_IN(clk_in), .RST_IN(rst_in), .SLEEP_IN_N_IN(sleep_n), .DRIVER_OFF_IN(drv_off),
        .BRIDGE_INPUT_A_IN(in_a), .BRIDGE_INPUT_B_IN(in_b), .SUPPLY_OV_CMP_IN(ov), .SUPPLY_OV_ALT_CMP_IN(1'b0),
        .SUPPLY_UV_CMP_IN(uv), .LOGIC_POR_CMP_IN(por), .THERMAL_SHUTDOWN_IN(thermal_shutdown), .OVERCURRENT_RAW_IN(1'b0),
        .CURRENT_LIMIT_CHOP_IN(1'b0), .RECIRC_EDGE_IN(rc_edge), .RECIRC_HIGH_SIDE_IN(hs), .SPIKE_SEEN_IN(spike),
        .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .FAULT_OUT_N_OUT(fault_n),
        .FAULT_OUT_N_OE_OUT(fault_oe), .BRIDGE_OUTPUT_A_OUT(out_a), .BRIDGE_OUTPUT_B_OUT(),
        .BRIDGE_OUTPUT_OE_OUT(br_oe), .CURRENT_PROP_OE_OUT(ip_oe), .OFFSTATE_DIAG_EN_OUT(), .STATE_OUT(state));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report
    task automatic hang_out;
        failures++;
        final_report();
    endtask : hang_out
    // one apb transfer; a read leaves its expected word on the queue
    task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] m, e);
        int n;
        n = 0;
        if (!wr) notes.push_back('{1'b0, m, e});
        @(posedge clk_in);
        psel   <= 1'b1;
        pwr    <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) hang_out();
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // pin vector is {bridge a, state, fault drive, bridge enable, current output enable}
    task automatic snap(input logic [5:0] m, e);
        notes.push_back('{1'b1, {27'h0000000, m}, {27'h0000000, e}});
        @(posedge clk_in);
        snap_req <= 1'b1;
        @(posedge clk_in);
        snap_req <= 1'b0;
    endtask : snap
    task automatic wait_state(input logic [1:0] s);
        int n;
        n = 0;
        while (state !== s && n < 3000) begin
            @(posedge clk_in);
            n++;
        end
        if (n >= 3000) hang_out();
    endtask : wait_state
    // three recirculation edges with random gaps between them
    task automatic recirc(input logic h, sp);
        repeat (3) begin
            @(posedge clk_in);
            hs      <= h;
            spike   <= sp;
            rc_edge <= 1'b1;
            @(posedge clk_in);
            rc_edge <= 1'b0;
            repeat (2 + $urandom % 4) @(posedge clk_in);
        end
    endtask : recirc
    ////////////////////////////////////////////////////////////////////////////////
    // scoreboard: oldest note against each read answer or pin snapshot
    always @(posedge clk_in) begin
        if ((snap_req || (pready && psel && penable && !pwr)) && notes.size() > 0) begin
            note = notes.pop_front();
            if (note.pin) `CHK("pins", note.exp & note.mask, {27'h0000000, out_a, state, fault_oe, br_oe, ip_oe} & note.mask)
            else `CHK("apb read", note.exp & note.mask, {pslverr, prdata} & note.mask)
        end
    end
    // main sequence; status 0x004 bit 31 write is the clear command
    initial begin
        bit ok;
        logic [31:0] r;
        void'($urandom(32'hF37E));
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        snap(5'h1F, 5'h00);
        r = $urandom & 32'h0000007F;
        apb(1'b0, 12'h000, 32'h0, 33'h0FFFFFFFF, 33'h00000001B);
        apb(1'b1, 12'h000, r, 33'h0, 33'h0);
        apb(1'b0, 12'h000, 32'h0, 33'h00000007F, {1'b0, r});
        apb(1'b1, 12'h000, 32'h0000001B, 33'h0, 33'h0);
        apb(1'b0, 12'h008, 32'h0, 33'h1FFFFFFFF, 33'h100000000);
        $display("test 1 registers done");
        u_host.ack_wake(ok);
        if (!ok) hang_out();
        wait_state(2'b10);
        snap(5'h1F, 5'b10000);
        u_host.low_pulse(5);
        repeat (30) @(posedge clk_in);
        snap(5'h1F, 5'b10000);
        $display("test 2 wake done");
        @(posedge clk_in) drv_off <= 1'b0;
        wait_state(2'b11);
        snap(6'h3F, 6'b111011);
        @(posedge clk_in) uv <= 1'b1;
        repeat (40) @(posedge clk_in);
        snap(5'h07, 5'b00100);
        @(posedge clk_in) uv <= 1'b0;
        repeat (40) @(posedge clk_in);
        snap(5'h1F, 5'b11011);
        $display("test 3 active and undervoltage done");
        recirc(1'b1, 1'b0);
        apb(1'b0, 12'h004, 32'h0, 33'h280, 33'h080);
        snap(5'h07, 5'b00111);
        recirc(1'b1, 1'b1);
        apb(1'b0, 12'h004, 32'h0, 33'h080, 33'h000);
        recirc(1'b0, 1'b0);
        apb(1'b0, 12'h004, 32'h0, 33'h080, 33'h000);
        apb(1'b1, 12'h000, 32'h0000001A, 33'h0, 33'h0);
        recirc(1'b1, 1'b0);
        apb(1'b0, 12'h004, 32'h0, 33'h080, 33'h000);
        apb(1'b1, 12'h000, 32'h00000019, 33'h0, 33'h0);
        recirc(1'b1, 1'b0);
        @(posedge clk_in) in_b <= 1'b1;
        apb(1'b1, 12'h004, 32'h80000000, 33'h0, 33'h0);
        apb(1'b0, 12'h004, 32'h0, 33'h080, 33'h080);
        @(posedge clk_in) in_b <= 1'b0;
        apb(1'b1, 12'h004, 32'h80000000, 33'h0, 33'h0);
        apb(1'b0, 12'h004, 32'h0, 33'h080, 33'h000);
        $display("test 4 open load done");
        @(posedge clk_in) ov <= 1'b1;
        repeat (40) @(posedge clk_in);
        apb(1'b0, 12'h004, 32'h0, 33'h020, 33'h000);
        apb(1'b1, 12'h000, 32'h0000001D, 33'h0, 33'h0);
        repeat (40) @(posedge clk_in);
        apb(1'b0, 12'h004, 32'h0, 33'h020, 33'h020);
        snap(5'h1F, 5'b11111);
        @(posedge clk_in) ov <= 1'b0;
        @(posedge clk_in) thermal_shutdown <= 1'b1;
        snap(5'h07, 5'b00100);
        @(posedge clk_in) thermal_shutdown <= 1'b0;
        @(posedge clk_in) drv_off <= 1'b1;
        wait_state(2'b10);
        snap(5'h1B, 5'b10000);
        $display("test 5 overvoltage and driver off done");
        u_host.low_pulse(450);
        snap(5'h1F, 5'h00);
        u_host.ack_wake(ok);
        if (!ok) hang_out();
        wait_state(2'b10);
        @(posedge clk_in) por <= 1'b1;
        repeat (40) @(posedge clk_in);
        snap(5'h1F, 5'h00);
        @(posedge clk_in) por <= 1'b0;
        u_host.ack_wake(ok);
        if (!ok) hang_out();
        wait_state(2'b10);
        snap(5'h1B, 5'b10000);
        $display("test 6 sleep and supply reset done");
        final_report();
    end
endmodule : bfsm_top_tb
`default_nettype wire
